// *** rtl/ecab_pkg.sv ***
// Package of constants and types for the configuration-access bridge
package ecab_pkg;

    // ======================================================================
    // Address decode
    // ======================================================================
    localparam int          ECAM_BUS_W   = 8;             // Bus field width n, 1..8
    localparam int          ECAM_BUS_LSB = 20;
    localparam int          ECAM_DEV_MSB = 19;
    localparam int          ECAM_DEV_LSB = 15;
    localparam int          ECAM_FN_MSB  = 14;
    localparam int          ECAM_FN_LSB  = 12;
    localparam int          ECAM_REG_MSB = 11;            // Extended register plus register
    localparam int          ECAM_REG_LSB = 2;
    localparam int          ECAM_ARI_MSB = 19;            // 8-bit function under ARI
    localparam int          ECAM_TAG_LSB = 28;            // Region select above the bus field
    localparam logic [3:0]  ECAM_BASE    = 4'he;          // Region at 0xe000_0000

    // ======================================================================
    // Root port identity and local header layout (dword indices)
    // ======================================================================
    localparam logic [4:0]  RP_DEV       = 5'h00;
    localparam logic [2:0]  RP_FN        = 3'h0;
    localparam logic [15:0] RP_VENDOR    = 16'h1234;      // Arbitrary value
    localparam logic [15:0] RP_DEVICE    = 16'h5678;      // Arbitrary value
    localparam logic [31:0] RP_CLASS     = 32'h0604_0000; // PCI-PCI bridge, revision 0
    localparam logic [31:0] RP_HDR       = 32'h0001_0000; // Header type 1
    localparam logic [31:0] RP_CAP_PTR   = 32'h0000_0040;
    localparam logic [31:0] RP_EXP_CAP   = 32'h0042_0010; // Version 2, root port
    localparam logic [31:0] RP_ROOT_CAP  = 32'h0001_0000; // Retry-status visibility present
    localparam logic [31:0] RP_DEV_CAP2  = 32'h0000_0020; // ARI forwarding supported

    localparam logic [9:0]  IX_ID        = 10'h000;
    localparam logic [9:0]  IX_CMD       = 10'h001;
    localparam logic [9:0]  IX_CLASS     = 10'h002;
    localparam logic [9:0]  IX_HDR       = 10'h003;
    localparam logic [9:0]  IX_BUS       = 10'h006;
    localparam logic [9:0]  IX_MEM       = 10'h008;
    localparam logic [9:0]  IX_PREF      = 10'h009;
    localparam logic [9:0]  IX_CAPP      = 10'h00d;
    localparam logic [9:0]  IX_BRCTL     = 10'h00f;
    localparam logic [9:0]  IX_EXP       = 10'h010;
    localparam logic [9:0]  IX_DEVCTL    = 10'h012;
    localparam logic [9:0]  IX_LNKCTL    = 10'h014;
    localparam logic [9:0]  IX_ROOT      = 10'h017;
    localparam logic [9:0]  IX_DEVCAP2   = 10'h019;
    localparam logic [9:0]  IX_DEVCTL2   = 10'h01a;

    // Writable bit masks and field positions
    localparam logic [31:0] MSK_LO16     = 32'h0000_ffff;
    localparam logic [31:0] MSK_HI16     = 32'hffff_0000;
    localparam logic [31:0] MSK_BUS      = 32'h00ff_ffff;
    localparam logic [31:0] MSK_WIN      = 32'hfff0_fff0;
    localparam int          LNK_DLLA_BIT = 29;
    localparam int          DEVCTL_UR_EN = 3;
    localparam int          ROOT_CRSSV   = 4;
    localparam int          DEVCTL2_ARI  = 5;

    // ======================================================================
    // Reset values and retry policy
    // ======================================================================
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES     = 32'hffff_ffff;
    localparam logic [31:0] CRS_VID_DATA = 32'hffff_0001;
    localparam logic [3:0]  RETRY_MAX    = 4'h4;

    // ======================================================================
    // Link request kinds and completion status
    // ======================================================================
    localparam logic [1:0]  KIND_CFG0    = 2'h0;
    localparam logic [1:0]  KIND_CFG1    = 2'h1;
    localparam logic [1:0]  KIND_MEM     = 2'h2;
    localparam logic [2:0]  CPL_SC       = 3'h0;
    localparam logic [2:0]  CPL_UR       = 3'h1;
    localparam logic [2:0]  CPL_CRS      = 3'h2;

    typedef enum logic [1:0] {
        ECAB_IDLE = 2'b00,
        ECAB_SEND = 2'b01,
        ECAB_WAIT = 2'b10
    } ecab_state_e;

endpackage : ecab_pkg

// *** rtl/ecab_bridge.sv ***
// Configuration-access bridge between the processor interconnect and the root port link
// Functional notes
// - Split configuration address into bus, device, function, register and byte fields.
// - Configuration accesses work after reset with no software setup.
// - Whole hierarchy below the host bridge lives in one configuration region.
// - Root port shows a type 1 header and express capability, honouring access types.
// - Memory accesses inside the configuration region become configuration transactions.
// - Reads to absent functions on the primary bus return all-ones.
// - Unsupported-request completion on a read returns all-ones; report only if enabled.
// - Link down: downstream configuration reads return all-ones without error.
// - Root port's own registers stay reachable while the link is down.
// - Bus above secondary and up to subordinate goes out as type 1.
// - Bus equal to secondary goes out as type 0, subject to device rules.
// - Requests to the root port itself are served by its local registers.
// - Memory requests inside either bridge window are forwarded downstream.
// - Memory requests outside both windows get an unsupported-request answer.
// - Retry status without visibility: reissue a few times, then all-ones.
// - Retry visibility on, non vendor-ID read: exhausted retries give all-ones.
// - Bus and function matching nothing known returns all-ones.
// - Secondary bus, ARI forwarding off, device nonzero: terminate with all-ones.
// - ARI forwarding on or device zero: forward secondary-bus request as type 0.
// - Accept aligned one, two and four byte configuration accesses with proper byte enables; memory requests carry all four.
// - With ARI forwarding, address bits 19 to 12 are one 8-bit function.
// - Requester ID of forwarded requests is the root port's own number.
module ecab_bridge
    import ecab_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Processor side
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [31:0] req_addr,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_wdata,
    output logic             resp_valid,
    output logic [31:0]      resp_rdata,
    output logic             resp_err,
    // Link side
    input  wire logic        link_up,
    output logic             down_valid,
    input  wire logic        down_ready,
    output logic [1:0]       down_kind,
    output logic             down_write,
    output logic [31:0]      down_addr,
    output logic [15:0]      down_bdf,
    output logic [3:0]       down_be,
    output logic [31:0]      down_wdata,
    output logic [15:0]      down_req_id,
    input  wire logic        cpl_valid,
    input  wire logic [2:0]  cpl_status,
    input  wire logic [31:0] cpl_data,
    output logic             err_report
);

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        ecab_state_e st;
        logic [3:0]  retry;
        logic        wr;
        logic        is_cfg;
        logic        vid_rd;
        logic [1:0]  kind;
        logic [31:0] addr;
        logic [15:0] bdf;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic        rsp_v;
        logic [31:0] rsp_d;
        logic        rsp_e;
        logic        err;
        logic [15:0] cmd;
        logic [23:0] bus;
        logic [31:0] mem;
        logic [31:0] pref;
        logic [15:0] brctl;
        logic [15:0] devctl;
        logic [15:0] lnkctl;
        logic [15:0] rootctl;
        logic [15:0] devctl2;
    } ecab_state_s;

    ecab_state_s s_reg;
    ecab_state_s s_next;

    // ======================================================================
    // Helpers
    // ======================================================================
    // Byte enables from size and offset; zero marks an unaligned access or size 3
    function automatic logic [3:0] size_be(input logic [1:0] sz, input logic [1:0] off);
        logic [3:0] be;
        be = 4'h0;
        case (sz)
            2'h0:    be = 4'h1 << off;
            2'h1:    be = off[0] ? 4'h0 : (4'h3 << off);
            2'h2:    be = (off == 2'h0) ? 4'hf : 4'h0;
            default: be = 4'h0;
        endcase
        return be;
    endfunction : size_be

    // Byte-lane write merge restricted to writable bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] msk);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~m) | (wd & m);
    endfunction : merge

    // Window check on 1 MB granules: base in [15:4], limit in [31:20]
    function automatic logic in_win(input logic [31:0] win, input logic [31:0] a);
        return (a[31:20] >= win[15:4]) && (a[31:20] <= win[31:20]);
    endfunction : in_win

    // ======================================================================
    // Request decode
    // ======================================================================
    logic [7:0] d_bus;
    logic [4:0] d_dev;
    logic [2:0] d_fn;
    logic [9:0] d_reg;
    logic [3:0] d_be;
    logic       d_ecam;
    logic       ari_fwd;
    logic       crs_sv;
    logic       ur_en;
    logic [7:0] prim_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;

    // Field split of the incoming address
    assign d_bus    = req_addr[ECAM_BUS_LSB +: ECAM_BUS_W];
    assign d_dev    = req_addr[ECAM_DEV_MSB:ECAM_DEV_LSB];
    assign d_fn     = req_addr[ECAM_FN_MSB:ECAM_FN_LSB];
    assign d_reg    = req_addr[ECAM_REG_MSB:ECAM_REG_LSB];
    assign d_be     = size_be(req_size, req_addr[1:0]);
    // One fixed region covers the whole hierarchy, so no programming is needed
    assign d_ecam   = (req_addr[31:ECAM_TAG_LSB] == ECAM_BASE);
    assign ari_fwd  = s_reg.devctl2[DEVCTL2_ARI];
    assign crs_sv   = s_reg.rootctl[ROOT_CRSSV];
    assign ur_en    = s_reg.devctl[DEVCTL_UR_EN];
    assign prim_bus = s_reg.bus[7:0];
    assign sec_bus  = s_reg.bus[15:8];
    assign sub_bus  = s_reg.bus[23:16];

    // ======================================================================
    // Local header read mux
    // ======================================================================
    // Read-only fields are constants, so software writes to them drop silently
    function automatic logic [31:0] cfg_read(input ecab_state_s s, input logic [9:0] ix, input logic up);
        logic [31:0] d;
        d = RST_ZERO;
        case (ix)
            IX_ID:      d = {RP_DEVICE, RP_VENDOR};
            IX_CMD:     d = {16'h0010, s.cmd};
            IX_CLASS:   d = RP_CLASS;
            IX_HDR:     d = RP_HDR;
            IX_BUS:     d = {8'h00, s.bus};
            IX_MEM:     d = s.mem;
            IX_PREF:    d = s.pref;
            IX_CAPP:    d = RP_CAP_PTR;
            IX_BRCTL:   d = {s.brctl, 16'h0000};
            IX_EXP:     d = RP_EXP_CAP;
            IX_DEVCTL:  d = {16'h0000, s.devctl};
            IX_LNKCTL:  d = {2'h0, up, 13'h0000, s.lnkctl};
            IX_ROOT:    d = RP_ROOT_CAP | {16'h0000, s.rootctl};
            IX_DEVCAP2: d = RP_DEV_CAP2;
            IX_DEVCTL2: d = {16'h0000, s.devctl2};
            default:    d = RST_ZERO;
        endcase
        return d;
    endfunction : cfg_read

    // ======================================================================
    // Next-state logic
    // ======================================================================
    // Single request in flight; the processor is held off until the answer is out
    always_comb begin
        logic [31:0] lw;
        lw         = RST_ZERO;
        s_next     = s_reg;
        s_next.rsp_v = 1'b0;
        s_next.err   = 1'b0;
        case (s_reg.st)
            ECAB_IDLE: begin
                if (req_valid) begin
                    s_next.wr     = req_write;
                    s_next.addr   = req_addr;
                    s_next.be     = d_be;
                    s_next.wdata  = req_wdata;
                    s_next.is_cfg = d_ecam;
                    s_next.retry  = 4'h0;
                    s_next.vid_rd = (d_reg == IX_ID) && (d_be[1:0] != 2'h0);
                    s_next.bdf    = {d_bus, d_dev, d_fn};
                    s_next.rsp_d  = ALL_ONES;
                    s_next.rsp_e  = 1'b0;
                    if (!d_ecam) begin
                        // Memory space: forward inside a window, refuse otherwise
                        if (in_win(s_reg.mem, req_addr) || in_win(s_reg.pref, req_addr)) begin
                            s_next.kind = KIND_MEM;
                            s_next.be   = 4'hf;
                            s_next.st   = ECAB_SEND;
                        end else begin
                            s_next.rsp_v = 1'b1;
                            s_next.rsp_e = 1'b1;
                        end
                    end else if (d_be == 4'h0) begin
                        s_next.rsp_v = 1'b1;
                    end else if (d_bus == prim_bus && d_dev == RP_DEV && d_fn == RP_FN) begin
                        // Local header works whatever the link state
                        s_next.rsp_v = 1'b1;
                        s_next.rsp_d = cfg_read(s_reg, d_reg, link_up);
                        if (req_write) begin
                            lw = cfg_read(s_reg, d_reg, link_up);
                            case (d_reg)
                                IX_CMD:     s_next.cmd     = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_LO16));
                                IX_BUS:     s_next.bus     = 24'(merge(lw, req_wdata, d_be,
                                                                   MSK_BUS));
                                IX_MEM:     s_next.mem     = merge(lw, req_wdata, d_be, MSK_WIN);
                                IX_PREF:    s_next.pref    = merge(lw, req_wdata, d_be, MSK_WIN);
                                IX_BRCTL:   s_next.brctl   = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_HI16) >> 16);
                                IX_DEVCTL:  s_next.devctl  = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_LO16));
                                IX_LNKCTL:  s_next.lnkctl  = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_LO16));
                                IX_ROOT:    s_next.rootctl = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_LO16));
                                IX_DEVCTL2: s_next.devctl2 = 16'(merge(lw, req_wdata, d_be,
                                                                   MSK_LO16));
                                default:    s_next.cmd     = s_reg.cmd;
                            endcase
                        end
                    end else if (d_bus == sec_bus) begin
                        if (!link_up) begin
                            s_next.rsp_v = 1'b1;
                        end else if (ari_fwd || d_dev == 5'h00) begin
                            // Under ARI the dev and fn fields read as one 8-bit function
                            s_next.bdf  = {d_bus, req_addr[ECAM_ARI_MSB:ECAM_FN_LSB]};
                            s_next.kind = KIND_CFG0;
                            s_next.st   = ECAB_SEND;
                        end else begin
                            s_next.rsp_v = 1'b1;
                        end
                    end else if (d_bus > sec_bus && d_bus <= sub_bus) begin
                        if (link_up) begin
                            s_next.kind = KIND_CFG1;
                            s_next.st   = ECAB_SEND;
                        end else begin
                            s_next.rsp_v = 1'b1;
                        end
                    end else begin
                        // Absent function on primary bus, or a bus nobody owns
                        s_next.rsp_v = 1'b1;
                    end
                end
            end
            ECAB_SEND: begin
                if (!link_up) begin
                    s_next.rsp_v = 1'b1;
                    s_next.st    = ECAB_IDLE;
                end else if (down_ready) begin
                    // Posted memory writes are answered as soon as the link takes them
                    if (s_reg.kind == KIND_MEM && s_reg.wr) begin
                        s_next.rsp_v = 1'b1;
                        s_next.st    = ECAB_IDLE;
                    end else begin
                        s_next.st = ECAB_WAIT;
                    end
                end
            end
            ECAB_WAIT: begin
                if (!link_up) begin
                    // A completion can never come once the link drops
                    s_next.rsp_v = 1'b1;
                    s_next.st    = ECAB_IDLE;
                end else if (cpl_valid) begin
                    s_next.st = ECAB_IDLE;
                    if (cpl_status == CPL_SC) begin
                        s_next.rsp_v = 1'b1;
                        s_next.rsp_d = s_reg.wr ? RST_ZERO : cpl_data;
                    end else if (cpl_status == CPL_CRS && s_reg.is_cfg && s_reg.retry < RETRY_MAX) begin
                        s_next.retry = s_reg.retry + 4'h1;
                        s_next.st    = ECAB_SEND;
                    end else if (cpl_status == CPL_CRS && s_reg.is_cfg) begin
                        s_next.rsp_v = 1'b1;
                        // Visible retry status only on vendor ID; everything else gives all-ones
                        s_next.rsp_d = (crs_sv && s_reg.vid_rd) ? CRS_VID_DATA : ALL_ONES;
                    end else begin
                        s_next.rsp_v = 1'b1;
                        s_next.rsp_e = !s_reg.is_cfg;
                        s_next.err   = (cpl_status == CPL_UR) && ur_en;
                    end
                end
            end
            default: begin
                s_next.st = ECAB_IDLE;
            end
        endcase
    end

    // ======================================================================
    // State register
    // ======================================================================
    // Reset values give working decode with no software action
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: ECAB_IDLE, retry: 4'h0, wr: 1'b0, is_cfg: 1'b0, vid_rd: 1'b0,
                       kind: KIND_CFG0, addr: RST_ZERO, bdf: 16'h0000, be: 4'h0, wdata: RST_ZERO,
                       rsp_v: 1'b0, rsp_d: RST_ZERO, rsp_e: 1'b0, err: 1'b0, cmd: 16'h0000,
                       bus: 24'h000000, mem: RST_ZERO, pref: RST_ZERO, brctl: 16'h0000,
                       devctl: 16'h0000, lnkctl: 16'h0000, rootctl: 16'h0000,
                       devctl2: 16'h0000};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Ready only when idle; the answer appears one cycle after acceptance at the earliest
    assign req_ready   = ce && (s_reg.st == ECAB_IDLE);
    assign resp_valid  = s_reg.rsp_v;
    assign resp_rdata  = s_reg.rsp_d;
    assign resp_err    = s_reg.rsp_e;
    assign err_report  = s_reg.err;
    assign down_valid  = ce && (s_reg.st == ECAB_SEND) && link_up;
    assign down_kind   = s_reg.kind;
    assign down_write  = s_reg.wr;
    assign down_addr   = s_reg.addr;
    assign down_bdf    = s_reg.bdf;
    assign down_be     = s_reg.be;
    assign down_wdata  = s_reg.wdata;
    assign down_req_id = {prim_bus, RP_DEV, RP_FN};

endmodule : ecab_bridge

// *** sim/ecab_checker.sv ***
// Port-level assertions for the configuration-access bridge
module ecab_checker import ecab_pkg::*; (
    input wire logic        sys_clk, rst_n, req_valid, req_ready, resp_valid, link_up, down_valid, err_report,
    input wire logic [31:0] req_addr, down_addr,
    input wire logic [15:0] down_bdf, down_req_id,
    input wire logic [1:0]  down_kind,
    input wire logic [3:0]  down_be
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Checks on the system clock; the root port number is read back off the requester ID
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence take_s; req_valid && req_ready; endsequence
    sequence self_s; take_s ##0 req_addr[31:12] == {ECAM_BASE, down_req_id[15:8], 8'h00}; endsequence
    sequence mem_s; take_s ##0 req_addr[31:28] != ECAM_BASE; endsequence
    chk_local_answer: assert property (self_s |=> resp_valid) else $error("local access late");
    chk_link_quiet: assert property (!link_up |-> !down_valid) else $error("sent on dead link");
    chk_dead_answer: assert property (take_s ##0 !link_up |-> ##[1:2] resp_valid) else $error("no answer");
    chk_req_ident: assert property (down_valid |-> down_req_id[7:0] == {RP_DEV, RP_FN}) else $error("bad id");
    chk_err_gated: assert property (err_report |-> resp_valid) else $error("stray error report");
    chk_mem_lanes: assert property (down_valid && down_kind == KIND_MEM |-> down_be == 4'hf) else $error("lanes");
    chk_cfg_fields: assert property (down_valid && down_kind != KIND_MEM |-> down_bdf == down_addr[27:12])
        else $error("target fields wrong");
    chk_mem_answer: assert property (mem_s |-> ##[1:2] (resp_valid || down_valid)) else $error("memory stuck");
endmodule : ecab_checker
bind ecab_bridge ecab_checker chk (.*);

// *** sim/ecab_link_model.sv ***
// Behavioural far end of the root port link
module ecab_link_model import ecab_pkg::*; (
    input  wire logic        sys_clk, rst_n, down_valid, down_write,
    input  wire logic [1:0]  down_kind,
    input  wire logic [2:0]  status, // Status given to every completion
    input  wire logic [3:0]  lat,    // Completion delay, slow when large
    output logic             down_ready, cpl_valid,
    output logic [2:0]       cpl_status,
    output logic [31:0]      cpl_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // One request at a time; a released data bus never repeats its last value
    logic       busy_reg;
    logic [3:0] wait_reg;
    assign down_ready = !busy_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) {busy_reg, wait_reg, cpl_valid, cpl_status, cpl_data} <= '0;
        else begin
            cpl_valid <= busy_reg && wait_reg == 4'h0;
            cpl_status <= status;
            cpl_data <= (busy_reg && wait_reg == 4'h0) ? 32'h0bad_cafe : ~cpl_data;
            wait_reg <= (down_valid && down_ready) ? lat : wait_reg - 4'h1;
            if (down_valid && down_ready) busy_reg <= !(down_write && down_kind == KIND_MEM); // Posted
            else if (wait_reg == 4'h0) busy_reg <= 1'b0;
        end
    end
endmodule : ecab_link_model

// *** sim/tb.sv ***
// Testbench: processor-side scenarios for the bridge against the link model
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb import ecab_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, ce = 1, req_valid = 0, req_write = 0, link_up = 1, req_ready, resp_valid, resp_err;
    logic down_valid, down_ready, down_write, cpl_valid, err_report;
    logic [31:0] req_addr = 0, req_wdata = 0, resp_rdata, down_addr, down_wdata, cpl_data, got;
    logic [15:0] down_bdf, down_req_id, bdf_seen;
    logic [1:0] req_size = 0, down_kind, kind_seen;
    logic [2:0] cpl_status, status = CPL_SC;
    logic [3:0] down_be, lat = 0;
    int errors = 0, comparisons = 0, cycles = 0;
    ecab_bridge dut (.*);
    ecab_link_model link (.*);
    // ====================
    // Clock, hang guard and a record of what the link accepted
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cycles > 3000) begin errors++; tally_and_finish(); end
    always @(posedge sys_clk) if (down_valid && down_ready) {kind_seen, bdf_seen} <= {down_kind, down_bdf};
    // One access: held until taken, then the answer is awaited under a bound
    task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d);
        @(posedge sys_clk) #1 {req_write, req_addr, req_size, req_wdata, req_valid} = {w, a, sz, d, 1'b1};
        while (!req_ready) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1 req_valid = 0;
        for (int n = 0; n < 80 && !resp_valid; n++) @(posedge sys_clk) #1;
        got = resp_rdata;
        `CHK(resp_valid, 1'b1)
    endtask : acc
    // Root port header, single byte lanes and bus numbers (secondary 1, subordinate 5)
    task automatic t_local;
        acc(0, 32'he000_0000, 2'h2, 0);
        `CHK(got, {RP_DEVICE, RP_VENDOR})
        acc(0, 32'he000_000e, 2'h0, 0);
        `CHK(got[23:16], 8'h01)
        acc(0, 32'he000_0002, 2'h1, 0);
        `CHK(got[31:16], RP_DEVICE)
        acc(0, 32'he000_0003, 2'h1, 0);
        `CHK(got, ALL_ONES)
        acc(1, 32'he000_0018, 2'h2, 32'h0005_0100);
        acc(0, 32'he000_0018, 2'h2, 0);
        `CHK(got[23:0], 24'h05_0100)
    endtask : t_local
    // Routing by bus and device number, then with ARI forwarding on
    task automatic t_route;
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK({kind_seen, got}, {KIND_CFG1, 32'h0bad_cafe})
        acc(0, 32'he010_0000, 2'h2, 0);
        `CHK(kind_seen, KIND_CFG0)
        kind_seen = 2'h3;
        acc(0, 32'he010_8000, 2'h2, 0);
        `CHK({kind_seen, got}, {2'h3, ALL_ONES})
        acc(0, 32'he090_0000, 2'h2, 0);
        `CHK({kind_seen, got}, {2'h3, ALL_ONES})
        acc(0, 32'he000_8000, 2'h2, 0);
        `CHK(got, ALL_ONES)
        acc(1, 32'he000_0068, 2'h2, 32'h0000_0020);
        acc(0, 32'he010_8000, 2'h2, 0);
        `CHK({kind_seen, bdf_seen}, {KIND_CFG0, 16'h0108})
    endtask : t_route
    // Faulty completions, dead link and memory windows (slow link answers from the dead-link step on)
    task automatic t_fault;
        status = CPL_UR;
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK({resp_err, err_report, got}, {2'h0, ALL_ONES})
        acc(1, 32'he000_0048, 2'h2, 32'h0000_0008);
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK({err_report, got}, {1'b1, ALL_ONES})
        status = CPL_CRS;
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK(got, ALL_ONES)
        acc(1, 32'he000_005c, 2'h2, 32'h0000_0010);
        acc(0, 32'he030_0004, 2'h2, 0);
        `CHK(got, ALL_ONES)
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK(got, CRS_VID_DATA)
        {status, link_up, lat} = {CPL_SC, 1'b0, 4'h6};
        acc(0, 32'he030_0000, 2'h2, 0);
        `CHK(got, ALL_ONES)
        acc(0, 32'he000_0000, 2'h2, 0);
        `CHK(got, {RP_DEVICE, RP_VENDOR})
        link_up = 1;
        acc(0, 32'h0000_0100, 2'h2, 0);
        `CHK({kind_seen, got}, {KIND_MEM, 32'h0bad_cafe})
        acc(0, 32'h4000_0000, 2'h2, 0);
        `CHK(resp_err, 1'b1)
    endtask : t_fault
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1;
        t_local();
        t_route();
        t_fault();
        tally_and_finish();
    end
endmodule : tb
